// file: logic/gppi_pkg.sv
// constants, types and register map of the gpio port with pin interrupts
package gppi_pkg;

  // port shape
  localparam int NPIN = 16;
  localparam int NSLOT = 8;
  localparam int NFUNC = 3;
  localparam int SELW = 4;
  localparam int ADDRW = 8;

  // register indices, byte address is four times the index
  localparam logic [5:0] R_DATA = 6'h00;
  localparam logic [5:0] R_DIR = 6'h01;
  localparam logic [5:0] R_SET = 6'h02;
  localparam logic [5:0] R_CLR = 6'h03;
  localparam logic [5:0] R_ISEL = 6'h04;
  localparam logic [5:0] R_IMODE = 6'h05;
  localparam logic [5:0] R_ISTAT = 6'h06;
  localparam logic [5:0] R_ICLR = 6'h07;
  localparam logic [5:0] R_IEN = 6'h08;
  localparam logic [5:0] R_FILT = 6'h09;
  localparam logic [5:0] R_PULL = 6'h0a;
  localparam logic [5:0] R_ODRAIN = 6'h0b;
  localparam logic [5:0] R_ANALOG = 6'h0c;
  localparam logic [5:0] R_FUNC = 6'h0d;

  // reset values: inputs with pull-up, two true open-drain pins without
  localparam logic [NPIN-1:0] PULL_RST = 16'hfff3;
  localparam logic [NPIN-1:0] ODRAIN_RST = 16'h000c;
  localparam logic [NPIN-1:0] LONG_FILT_PINS = 16'h000c;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;

  // filter timing
  localparam int MCLK_NS = 25;
  localparam int FILT_SHORT_NS = 10;
  localparam int FILT_LONG_NS = 50;
  localparam int FS_CYC_RAW = (FILT_SHORT_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int FL_CYC_RAW = (FILT_LONG_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [1:0] FILT_SHORT_CYC = 2'((FS_CYC_RAW < 1) ? 1 : FS_CYC_RAW);
  localparam logic [1:0] FILT_LONG_CYC = 2'((FL_CYC_RAW < 1) ? 1 : FL_CYC_RAW);

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] FUNC_GPIO = 2'h0;

  typedef enum logic [1:0] {
    GPPI_LEVEL,
    GPPI_RISE,
    GPPI_FALL,
    GPPI_BOTH
  } gppi_mode_t;

  // pad drive group
  typedef struct packed {
    logic [NPIN-1:0] o;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pu;
  } gppi_pad_t;

  // peripheral drive group, one lane per alternate function
  typedef struct packed {
    logic [NFUNC-1:0][NPIN-1:0] o;
    logic [NFUNC-1:0][NPIN-1:0] oe;
  } gppi_periph_t;

endpackage

// file: logic/gppi_port.sv
// gpio port: pin mux, direction, set/clear, filters, pin interrupts
// How it works
// - software drives or samples every unmuxed pin; direction per pin at run time.
// - one write to set or clear register changes only the selected output bits.
// - one write to the data register loads the whole port value.
// - eight slots pick any pin; level, rising, falling or both edges.
// - any pin may be picked as an interrupt source, with or without its glitch filter.
// - filter rejects 10 ns pulses on most pins, 50 ns on two pins.
// - a per-pin function field selects gpio or one of the peripherals.
// - analog mode cuts the pin's digital input and output paths.
// - each pin has an optional pull-up and an open-drain output mode.
// - eight pin interrupt lines go to the vectored controller and wake logic.
// - each pin source drives one line; a summary line ORs all enabled flags.
// - after reset pins are inputs with pull-up, except two open-drain pins.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module gppi_port
  import gppi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // axi4-lite write
  input wire logic [ADDRW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDRW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pads
  input wire logic [NPIN-1:0] pad_in,
  output gppi_pad_t pad_out,
  // peripherals
  input wire gppi_periph_t periph_drive,
  output logic [NPIN-1:0] periph_in,
  // interrupts
  output logic [NSLOT-1:0] pin_irq,
  output logic irq
);

  // write channel
  logic aw_got_reg;
  logic w_got_reg;
  logic [5:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] wmask_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_go;
  logic wr_hit;

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign wr_go = aw_got_reg && w_got_reg && !bvalid_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_got_reg <= 1'b0;
      waddr_reg <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg <= 1'b1;
      waddr_reg <= s_axi_awaddr[7:2];
    end else if (wr_go) begin
      aw_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      w_got_reg <= 1'b0;
      wdata_reg <= ZERO_RST;
      wmask_reg <= ZERO_RST;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wmask_reg <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end else if (wr_go) begin
      w_got_reg <= 1'b0;
    end
  end

  always_comb begin
    case (waddr_reg)
      R_DATA, R_DIR, R_SET, R_CLR, R_ISEL, R_IMODE, R_ICLR, R_IEN,
      R_FILT, R_PULL, R_ODRAIN, R_ANALOG, R_FUNC: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // write strobes per register
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask_reg) | (wdata_reg & wmask_reg);
  endfunction

  function automatic logic [NPIN-1:0] merge_lo(input logic [NPIN-1:0] old);
    merge_lo = (old & ~wmask_reg[NPIN-1:0]) | (wdata_reg[NPIN-1:0] & wmask_reg[NPIN-1:0]);
  endfunction

  logic wr_data;
  logic wr_set;
  logic wr_clr;
  logic [NPIN-1:0] wlo;
  assign wr_data = wr_go && (waddr_reg == R_DATA);
  assign wr_set = wr_go && (waddr_reg == R_SET);
  assign wr_clr = wr_go && (waddr_reg == R_CLR);
  assign wlo = wdata_reg[NPIN-1:0] & wmask_reg[NPIN-1:0];

  // port output and configuration
  logic [NPIN-1:0] out_reg;
  logic [NPIN-1:0] dir_reg;
  logic [NPIN-1:0] filt_reg;
  logic [NPIN-1:0] pull_reg;
  logic [NPIN-1:0] odrain_reg;
  logic [NPIN-1:0] analog_reg;
  logic [31:0] func_reg;
  logic [31:0] isel_reg;
  logic [31:0] imode_reg;
  logic [NSLOT-1:0] ien_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= ZERO_RST[NPIN-1:0];
    end else if (wr_data) begin
      out_reg <= merge_lo(out_reg);
    end else if (wr_set) begin
      out_reg <= out_reg | wlo;
    end else if (wr_clr) begin
      out_reg <= out_reg & ~wlo;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dir_reg <= ZERO_RST[NPIN-1:0];
      pull_reg <= PULL_RST;
      odrain_reg <= ODRAIN_RST;
      filt_reg <= ZERO_RST[NPIN-1:0];
      analog_reg <= ZERO_RST[NPIN-1:0];
      func_reg <= ZERO_RST;
      isel_reg <= ZERO_RST;
      imode_reg <= ZERO_RST;
      ien_reg <= ZERO_RST[NSLOT-1:0];
    end else if (wr_go) begin
      case (waddr_reg)
        R_DIR: dir_reg <= merge_lo(dir_reg);
        R_PULL: pull_reg <= merge_lo(pull_reg);
        R_ODRAIN: odrain_reg <= merge_lo(odrain_reg);
        R_FILT: filt_reg <= merge_lo(filt_reg);
        R_ANALOG: analog_reg <= merge_lo(analog_reg);
        R_FUNC: func_reg <= merge(func_reg);
        R_ISEL: isel_reg <= merge(isel_reg);
        R_IMODE: imode_reg <= merge({16'h0000, imode_reg[15:0]});
        R_IEN: ien_reg <= NSLOT'(merge_lo({8'h00, ien_reg}));
        default: ;
      endcase
    end
  end

  // input sync, glitch filter, pad drive per pin
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic [NPIN-1:0] clean_reg;
  logic [NPIN-1:0] pin_val;
  gppi_pad_t pad_next;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= PULL_RST;
      sync2_reg <= PULL_RST;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic [1:0] cnt_reg;
      logic [1:0] thr;
      logic [1:0] fsel;
      logic drv;
      logic val;
      assign thr = LONG_FILT_PINS[gi] ? FILT_LONG_CYC : FILT_SHORT_CYC;
      assign fsel = func_reg[2*gi +: 2];
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          cnt_reg <= 2'h0;
          clean_reg[gi] <= PULL_RST[gi];
        end else if (!filt_reg[gi] || sync2_reg[gi] == clean_reg[gi]) begin
          cnt_reg <= 2'h0;
          clean_reg[gi] <= sync2_reg[gi];
        end else if (cnt_reg >= thr) begin
          cnt_reg <= 2'h0;
          clean_reg[gi] <= sync2_reg[gi];
        end else begin
          cnt_reg <= cnt_reg + 2'h1;
        end
      end
      always_comb begin
        if (fsel == FUNC_GPIO) begin
          drv = dir_reg[gi];
          val = out_reg[gi];
        end else begin
          drv = periph_drive.oe[fsel - 2'h1][gi];
          val = periph_drive.o[fsel - 2'h1][gi];
        end
        pad_next.o[gi] = val & ~analog_reg[gi] & ~odrain_reg[gi];
        pad_next.oe[gi] = drv & ~analog_reg[gi] & ~(odrain_reg[gi] & val);
        pad_next.pu[gi] = pull_reg[gi] & ~analog_reg[gi];
      end
    end
  endgenerate

  assign pin_val = clean_reg & ~analog_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pad_out <= '{o: ZERO_RST[NPIN-1:0], oe: ZERO_RST[NPIN-1:0], pu: PULL_RST};
      periph_in <= ZERO_RST[NPIN-1:0];
    end else begin
      pad_out <= pad_next;
      periph_in <= pin_val;
    end
  end

  // pin interrupt slots
  logic [NPIN-1:0] prev_reg;
  logic [NSLOT-1:0] hit;
  logic [NSLOT-1:0] istat_reg;
  logic [NSLOT-1:0] iclr;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_reg <= PULL_RST;
    end else begin
      prev_reg <= pin_val;
    end
  end

  generate
    for (gi = 0; gi < NSLOT; gi++) begin : g_slot
      logic [SELW-1:0] pin;
      logic cur;
      logic old;
      assign pin = isel_reg[SELW*gi +: SELW];
      assign cur = pin_val[pin];
      assign old = prev_reg[pin];
      always_comb begin
        case (gppi_mode_t'(imode_reg[2*gi +: 2]))
          GPPI_LEVEL: hit[gi] = cur;
          GPPI_RISE: hit[gi] = cur & ~old;
          GPPI_FALL: hit[gi] = ~cur & old;
          GPPI_BOTH: hit[gi] = cur ^ old;
          default: hit[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  assign iclr = (wr_go && waddr_reg == R_ICLR) ?
                (wdata_reg[NSLOT-1:0] & wmask_reg[NSLOT-1:0]) : ZERO_RST[NSLOT-1:0];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      istat_reg <= ZERO_RST[NSLOT-1:0];
    end else begin
      istat_reg <= (istat_reg & ~iclr) | hit;
    end
  end

  assign pin_irq = istat_reg & ien_reg;
  assign irq = |pin_irq;

  // read channel
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rd_val;
  logic rd_hit;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = ZERO_RST;
    case (s_axi_araddr[7:2])
      R_DATA: rd_val[NPIN-1:0] = pin_val;
      R_DIR: rd_val[NPIN-1:0] = dir_reg;
      R_SET, R_CLR, R_ICLR: rd_val = ZERO_RST;
      R_ISEL: rd_val = isel_reg;
      R_IMODE: rd_val[15:0] = imode_reg[15:0];
      R_ISTAT: rd_val[NSLOT-1:0] = istat_reg;
      R_IEN: rd_val[NSLOT-1:0] = ien_reg;
      R_FILT: rd_val[NPIN-1:0] = filt_reg;
      R_PULL: rd_val[NPIN-1:0] = pull_reg;
      R_ODRAIN: rd_val[NPIN-1:0] = odrain_reg;
      R_ANALOG: rd_val[NPIN-1:0] = analog_reg;
      R_FUNC: rd_val = func_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= ZERO_RST;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: tb/gppi_port_asserts.sv
// assertions on the gpio port bus handshakes, pads and interrupt lines
`timescale 1ns/10ps
`default_nettype none
module gppi_port_asserts
  import gppi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pads and interrupts
  input wire gppi_pad_t pad_out,
  input wire logic [NSLOT-1:0] pin_irq,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_irq_or_lines: assert property ($fell(irq) |-> s_axi_bvalid && !(|pin_irq))
    else $error("irq dropped without a bus write or with a pin line still high");
  chk_reset_pads: assert property ($rose(rstn) |-> pad_out.pu == 16'hfff3 && pad_out.oe == 16'h0000)
    else $error("pads not inputs with pull-up after reset");
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_taken: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  chk_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write response late");
  chk_wr_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// file: tb/gppi_pins_model.sv
// external pins: pad drive loopback, pull-ups, bench levels
`timescale 1ns/10ps
`default_nettype none
module gppi_pins_model
  import gppi_pkg::*;
(
  // clock
  input wire logic mclk,
  // pins
  input wire gppi_pad_t pad_out,
  input wire logic [NPIN-1:0] ext_oe,
  input wire logic [NPIN-1:0] ext_val,
  output logic [NPIN-1:0] pad_in
);
  logic [NPIN-1:0] float_pat = 16'h5555;
  always @(posedge mclk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_out.oe[i]) pad_in[i] = pad_out.o[i];
      else if (ext_oe[i]) pad_in[i] = ext_val[i];
      else if (pad_out.pu[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_pat[i];
    end
  end
endmodule
`default_nettype wire

// file: tb/gppi_port_bench.sv
// bench for the gpio port: bus tasks, pin stimulus, checks
`timescale 1ns/10ps
`default_nettype none
module gppi_port_bench;
  import gppi_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0;
  logic [ADDRW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [NPIN-1:0] pad_in, periph_in, ext_oe = 16'h0000, ext_val = 16'h0000;
  logic [NSLOT-1:0] pin_irq;
  gppi_pad_t pad_out;
  gppi_periph_t periph_drive = {48'h0000_0000_ffff, 48'h0000_0000_ffff};
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  gppi_port gppi_port_inst (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out,
    .periph_drive, .periph_in, .pin_irq, .irq);
  gppi_pins_model gppi_pins_model_inst (.mclk, .pad_out, .ext_oe, .ext_val, .pad_in);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rdr(input logic [5:0] idx);
    @(posedge mclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [5:0] idx, input logic [31:0] e);
    rdr(idx);
    chk(nm, e, rd);
  endtask
  task automatic give_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rchk("pull", R_PULL, 32'h0000_fff3);
    rchk("odrain", R_ODRAIN, 32'h0000_000c);
    chk("rst oe", 32'h0, {16'h0, pad_out.oe});
    wr(R_DIR, 32'h0000_ffff, RESP_OKAY);
    wr(R_DATA, 32'h0000_a5c3, RESP_OKAY);
    wr(R_SET, 32'h0000_0005, RESP_OKAY);
    wr(R_CLR, 32'h0000_00c0, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("pad o", 32'h0000_a503, {16'h0, pad_out.o});
    chk("pad oe", 32'h0000_fffb, {16'h0, pad_out.oe});
    repeat (4) @(posedge mclk);
    rdr(R_DATA);
    chk("data in", 32'h0000_a503, rd & 32'h0000_fffb);
    chk("periph in", 32'h0000_a503, {16'h0, periph_in} & 32'h0000_fffb);
    wr(R_ANALOG, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("an oe", 32'h0000_fffa, {16'h0, pad_out.oe});
    chk("an pu", 32'h0000_fff2, {16'h0, pad_out.pu});
    wr(R_ANALOG, 32'h0, RESP_OKAY);
    wr(R_FUNC, 32'h0000_0100, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("func o", 32'h0000_a513, {16'h0, pad_out.o});
    wr(R_FUNC, 32'h0, RESP_OKAY);
    wr(6'h3f, 32'hffff_ffff, RESP_SLVERR);
    rdr(6'h3f);
    chk("unm data", 32'h0, rd);
    chk("unm resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    ext_oe <= 16'h01e0;
    wr(R_DIR, 32'h0, RESP_OKAY);
    wr(R_ISEL, 32'h0000_8765, RESP_OKAY);
    wr(R_IMODE, 32'h0000_aa39, RESP_OKAY);
    wr(R_IEN, 32'h0000_000f, RESP_OKAY);
    repeat (8) @(posedge mclk);
    wr(R_ICLR, 32'h0000_00ff, RESP_OKAY);
    rchk("ist idle", R_ISTAT, 32'h0);
    ext_val <= 16'h01e0;
    repeat (8) @(posedge mclk);
    rchk("ist rise", R_ISTAT, 32'h0000_000d);
    chk("pin_irq", 32'h0000_000d, {24'h0, pin_irq});
    chk("irq", 32'h1, {31'h0, irq});
    wr(R_IEN, 32'h0000_0001, RESP_OKAY);
    wr(R_ICLR, 32'h0000_000f, RESP_OKAY);
    rchk("ist level", R_ISTAT, 32'h0000_0008);
    ext_val <= 16'h0000;
    repeat (8) @(posedge mclk);
    rchk("ist fall", R_ISTAT, 32'h0000_000e);
    chk("masked", 32'h0, {24'h0, pin_irq});
    wr(R_FILT, 32'h0000_0020, RESP_OKAY);
    wr(R_ICLR, 32'h0000_00ff, RESP_OKAY);
    ext_val <= 16'h0020;
    @(posedge mclk);
    ext_val <= 16'h0000;
    repeat (8) @(posedge mclk);
    rchk("glitch", R_ISTAT, 32'h0);
    ext_val <= 16'h0020;
    repeat (4) @(posedge mclk);
    ext_val <= 16'h0000;
    repeat (8) @(posedge mclk);
    rchk("pulse", R_ISTAT, 32'h0000_0001);
    give_verdict();
  end
endmodule
bind gppi_port gppi_port_asserts gppi_port_asserts_inst (.mclk, .rstn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pad_out, .pin_irq, .irq);
`default_nettype wire
